/* hdl/rfcc_defs.svh */
`ifndef RFCC_DEFS_SVH
`define RFCC_DEFS_SVH

// --------------------------------------------------------------------------
// command and reply framing
// --------------------------------------------------------------------------
`define RFCC_OPCODE        16'hE007
`define RFCC_RFU_FIELD     8'h00
`define RFCC_CMD_BITS      7'd72
`define RFCC_CMD_BODY      7'd56
`define RFCC_RPL_BITS      7'd49
`define RFCC_RPL_BODY      7'd33

// --------------------------------------------------------------------------
// crc-16
// --------------------------------------------------------------------------
`define RFCC_CRC_PRESET    16'hFFFF
`define RFCC_CRC_POLY      16'h1021
`define RFCC_CRC_RESIDUE   16'h1D0F

// --------------------------------------------------------------------------
// feature word layout, vector index = 15 - bit number on air
// --------------------------------------------------------------------------
`define RFCC_CFG_ADDR      16'h0200
`define RFCC_B_TAMPER      15
`define RFCC_B_EXT_SUPPLY  14
`define RFCC_B_INV_OUT     11
`define RFCC_B_TRANSP      10
`define RFCC_B_DATA_RAW    9
`define RFCC_B_RANGE_RED   4
`define RFCC_B_PSF         0
`define RFCC_IND_MASK      16'hC000
`define RFCC_RFU_MASK      16'h3000
`define RFCC_TEMP_MASK     16'h0E00
`define RFCC_PERM_MASK     16'h01FF
`define RFCC_PERM_RESET    9'h040

// --------------------------------------------------------------------------
// memory layout
// --------------------------------------------------------------------------
`define RFCC_EXT_EPC_BITS  10'd128
`define RFCC_EXT_USER_BITS 10'd640
`define RFCC_BASE_EPC_BITS 10'd256
`define RFCC_BASE_USER_BITS 10'd512
`define RFCC_EPC_MAX_BLOCKS 5

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define RFCC_CLK_HZ        50_000_000
`define RFCC_CW_MAX_MS     20
`define RFCC_CW_MAX_CYC    ((`RFCC_CW_MAX_MS * `RFCC_CLK_HZ) / 1000)

// --------------------------------------------------------------------------
// reader register map (apb)
// --------------------------------------------------------------------------
`define RFCC_A_CTRL        8'h00
`define RFCC_A_STAT        8'h04
`define RFCC_A_MASK        8'h08
`define RFCC_A_HANDLE      8'h0C
`define RFCC_A_RN16        8'h10
`define RFCC_A_REPLY       8'h14
`define RFCC_S_BUSY        0
`define RFCC_S_DONE        1
`define RFCC_S_TIMEOUT     2
`define RFCC_S_ERROR       3
`define RFCC_S_BADCRC      4
`define RFCC_S_EXTPRE      5

`endif

/* hdl/rfcc_pkg.sv */
package rfcc_pkg;

  typedef enum logic [2:0] {
    G2_READY, G2_ARBITRATE, G2_REPLY, G2_ACKNOWLEDGED, G2_OPEN, G2_SECURED, G2_KILLED
  } rfcc_gen2_state_t;

  typedef enum {T_IDLE, T_RX, T_EVAL, T_NVM, T_LOAD, T_TX} rfcc_tag_st_t;

  typedef enum {H_IDLE, H_REQ, H_FS, H_SEND, H_WAIT, H_CHK} rfcc_host_st_t;

endpackage

/* hdl/rfcc_air_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface rfcc_air_if;
  logic req_rn;
  logic fs;
  logic rx_valid;
  logic rx_bit;
  logic cw;
  logic tx_valid;
  logic tx_bit;
  logic tx_last;
  logic tx_ext_pre;
  logic tx_err;

  modport reader (
    output req_rn, fs, rx_valid, rx_bit, cw,
    input  tx_valid, tx_bit, tx_last, tx_ext_pre, tx_err
  );

  modport tag (
    input  req_rn, fs, rx_valid, rx_bit, cw,
    output tx_valid, tx_bit, tx_last, tx_ext_pre, tx_err
  );
endinterface

`default_nettype wire

/* hdl/rfcc_crc16.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rfcc_defs.svh"

module rfcc_crc16 (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic        din,
  input  wire logic        shift,
  output logic [15:0]      crc
);
  logic [15:0] crc_reg;
  logic        fb;

  // --------------------------------------------------------------------------
  // serial crc, msb first; shift walks the register out for transmission
  // --------------------------------------------------------------------------
  assign fb  = crc_reg[15] ^ din;
  assign crc = crc_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      crc_reg <= `RFCC_CRC_PRESET;
    end else if (init) begin
      crc_reg <= `RFCC_CRC_PRESET;
    end else if (en) begin
      crc_reg <= {crc_reg[14:0], 1'b0} ^ (fb ? `RFCC_CRC_POLY : 16'h0000);
    end else if (shift) begin
      crc_reg <= {crc_reg[14:0], 1'b0};
    end
  end
endmodule

`default_nettype wire

/* hdl/rfcc_tag.sv */
// Behaviour
// - opcode, rfu, data, handle, crc in order
// - data is mask xor rn16
// - accepted toggle inverts selected word bits
// - reply: zero header, word, handle, crc
// - execute only open/secured; arbitrate group falls back
// - open or zero password: report only
// - secured: reply after change completes
// - bad crc or handle: silent discard
// - crc covers opcode through handle
// - frame-sync and prior req_rn required
// - mask on rfu bits discards command
// - indicator bits never changed by command
// - reply to change uses extended preamble
// - reader holds cw, 20 ms limit
// - internal failure backscatters error code
// - word at 200h, readable and selectable
// - standard write only while bank unlocked
// - bits 0..7 field layout
// - bits 8..15 field layout
// - bit 0 is msb, sent first
// - temporary bits clear at power up
// - extended: 128 epc, grows to 448
// - base: 256 epc, 512 user
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rfcc_defs.svh"

module rfcc_tag #(
  parameter bit EXTENDED        = 1'b1,
  parameter int EPC_MAX_BLOCKS  = `RFCC_EPC_MAX_BLOCKS
) (
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  rfcc_air_if.tag                         air,
  input  wire rfcc_pkg::rfcc_gen2_state_t gen2_state,
  input  wire logic [15:0]                handle,
  input  wire logic [15:0]                rn16,
  input  wire logic                       access_pw_zero,
  input  wire logic                       epc_locked,
  input  wire logic                       tamper_pad,
  input  wire logic                       ext_supply_pad,
  input  wire logic [8:0]                 nvm_perm,
  input  wire logic                       nvm_done,
  input  wire logic                       nvm_fail,
  input  wire logic                       wr_req,
  input  wire logic [15:0]                wr_data,
  input  wire logic [2:0]                 epc_extra_blocks,
  output logic                            nvm_wr,
  output logic [8:0]                      nvm_wdata,
  output logic [15:0]                     cfg_word,
  output logic                            go_arbitrate,
  output logic [9:0]                      epc_len_bits,
  output logic [9:0]                      user_len_bits
);
  if (EPC_MAX_BLOCKS < 0 || EPC_MAX_BLOCKS > `RFCC_EPC_MAX_BLOCKS) begin : g_bad_blocks
    $error("EPC_MAX_BLOCKS out of range");
  end

  rfcc_pkg::rfcc_tag_st_t st_reg, st_next;
  logic [6:0]  cnt_reg;
  logic [55:0] sh_reg;
  logic [32:0] txsh_reg;
  logic [2:0]  temp_reg, temp_next;
  logic [8:0]  perm_reg, perm_next;
  logic [8:0]  nvm_wdata_reg, nvm_wdata_next;
  logic        loaded_reg;
  logic        req_reg, req_next;
  logic        ext_reg, ext_next;
  logic        nvm_wr_reg, nvm_wr_next;
  logic        arb_reg, arb_next;
  logic        err_reg, err_next;
  logic [15:0] crc;
  logic [1:0]  pad_in;
  logic [1:0]  pad_s;

  // --------------------------------------------------------------------------
  // pad inputs: four flops, change taken once stages two and three agree
  // --------------------------------------------------------------------------
  assign pad_in = {tamper_pad, ext_supply_pad};

  for (genvar i = 0; i < 2; i++) begin : g_pad
    logic s1, s2, s3, q;
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        q  <= 1'b0;
      end else begin
        s1 <= pad_in[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          q <= s3;
        end
      end
    end
    assign pad_s[i] = q;
  end

  // --------------------------------------------------------------------------
  // feature word and memory sizes
  // --------------------------------------------------------------------------
  assign cfg_word = {pad_s, 2'b00, temp_reg, perm_reg};

  wire [2:0] blk_c = (32'(epc_extra_blocks) > EPC_MAX_BLOCKS) ?
                     3'(EPC_MAX_BLOCKS) : epc_extra_blocks;
  wire [9:0] epc_add = {1'b0, blk_c, 6'd0};
  assign epc_len_bits  = EXTENDED ? `RFCC_EXT_EPC_BITS + epc_add
                                  : `RFCC_BASE_EPC_BITS;
  assign user_len_bits = EXTENDED ? `RFCC_EXT_USER_BITS - epc_add
                                  : `RFCC_BASE_USER_BITS;

  // --------------------------------------------------------------------------
  // received frame decode
  // --------------------------------------------------------------------------
  wire [15:0] rx_opc    = sh_reg[55:40];
  wire [15:0] rx_data   = sh_reg[31:16];
  wire [15:0] rx_hdl    = sh_reg[15:0];
  wire        opc_hit   = (rx_opc == `RFCC_OPCODE);
  wire        crc_ok    = (crc == `RFCC_CRC_RESIDUE);
  wire        frame_ok  = opc_hit && crc_ok && (rx_hdl == handle) && req_reg;
  wire [15:0] mask      = rx_data ^ rn16;
  wire        rfu_hit   = |(mask & `RFCC_RFU_MASK);
  wire        st_exec   = (gen2_state == rfcc_pkg::G2_OPEN) ||
                          (gen2_state == rfcc_pkg::G2_SECURED);
  wire        st_arb    = (gen2_state == rfcc_pkg::G2_ARBITRATE) ||
                          (gen2_state == rfcc_pkg::G2_REPLY) ||
                          (gen2_state == rfcc_pkg::G2_ACKNOWLEDGED);
  wire        rpt_only  = (gen2_state == rfcc_pkg::G2_OPEN) || access_pw_zero;
  wire [15:0] eff       = rpt_only ? 16'h0000
                          : (mask & ~(`RFCC_IND_MASK | `RFCC_RFU_MASK));
  wire [15:0] eff_perm  = eff & `RFCC_PERM_MASK;
  wire [15:0] eff_temp  = eff & `RFCC_TEMP_MASK;
  wire        wr_ok     = wr_req && !epc_locked;
  wire        in_tx     = (st_reg == rfcc_pkg::T_TX);
  wire        tx_body   = in_tx && (cnt_reg < `RFCC_RPL_BODY);

  // --------------------------------------------------------------------------
  // command sequencing
  // --------------------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    temp_next      = temp_reg;
    perm_next      = perm_reg;
    nvm_wdata_next = nvm_wdata_reg;
    nvm_wr_next    = 1'b0;
    arb_next       = 1'b0;
    err_next       = 1'b0;
    ext_next       = ext_reg;
    req_next       = req_reg | air.req_rn;
    unique case (st_reg)
      rfcc_pkg::T_IDLE: begin
        if (air.fs) begin
          st_next = rfcc_pkg::T_RX;
        end else if (wr_ok) begin
          temp_next      = wr_data[11:9];
          perm_next      = wr_data[8:0];
          nvm_wdata_next = wr_data[8:0];
          nvm_wr_next    = 1'b1;
        end
      end
      rfcc_pkg::T_RX: begin
        if (air.rx_valid && !air.fs && cnt_reg == `RFCC_CMD_BITS - 7'd1) begin
          st_next = rfcc_pkg::T_EVAL;
        end
      end
      rfcc_pkg::T_EVAL: begin
        st_next = rfcc_pkg::T_IDLE;
        if (opc_hit && st_arb) begin
          arb_next = 1'b1;
        end else if (st_exec && frame_ok && !rfu_hit) begin
          req_next  = air.req_rn;
          ext_next  = (eff != 16'h0000);
          temp_next = temp_reg ^ eff_temp[11:9];
          if (eff_perm != 16'h0000) begin
            nvm_wdata_next = perm_reg ^ eff_perm[8:0];
            nvm_wr_next    = 1'b1;
            st_next        = rfcc_pkg::T_NVM;
          end else begin
            st_next = rfcc_pkg::T_LOAD;
          end
        end
      end
      rfcc_pkg::T_NVM: begin
        if (nvm_fail) begin
          err_next = 1'b1;
          st_next  = rfcc_pkg::T_IDLE;
        end else if (nvm_done) begin
          perm_next = nvm_wdata_reg;
          st_next   = rfcc_pkg::T_LOAD;
        end
      end
      rfcc_pkg::T_LOAD: begin
        st_next = rfcc_pkg::T_TX;
      end
      rfcc_pkg::T_TX: begin
        if (cnt_reg == `RFCC_RPL_BITS - 7'd1) begin
          st_next = rfcc_pkg::T_IDLE;
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // crc shared by receive check and reply generation
  // --------------------------------------------------------------------------
  wire crc_init = ((st_reg == rfcc_pkg::T_IDLE || st_reg == rfcc_pkg::T_RX) && air.fs) ||
                  (st_reg == rfcc_pkg::T_LOAD);
  wire crc_en   = ((st_reg == rfcc_pkg::T_RX) && air.rx_valid) || tx_body;
  wire crc_din  = in_tx ? txsh_reg[32] : air.rx_bit;

  rfcc_crc16 u_crc (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .init    (crc_init),
    .en      (crc_en),
    .din     (crc_din),
    .shift   (in_tx && !tx_body),
    .crc     (crc)
  );

  // --------------------------------------------------------------------------
  // reply serialiser
  // --------------------------------------------------------------------------
  assign air.tx_valid   = in_tx;
  assign air.tx_bit     = tx_body ? txsh_reg[32] : ~crc[15];
  assign air.tx_last    = in_tx && (cnt_reg == `RFCC_RPL_BITS - 7'd1);
  assign air.tx_ext_pre = in_tx && ext_reg;
  assign air.tx_err     = err_reg;
  assign go_arbitrate   = arb_reg;
  assign nvm_wr         = nvm_wr_reg;
  assign nvm_wdata      = nvm_wdata_reg;

  // --------------------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg        <= rfcc_pkg::T_IDLE;
      temp_reg      <= 3'b000;
      perm_reg      <= `RFCC_PERM_RESET;
      loaded_reg    <= 1'b0;
      nvm_wdata_reg <= 9'h000;
      nvm_wr_reg    <= 1'b0;
      arb_reg       <= 1'b0;
      err_reg       <= 1'b0;
      ext_reg       <= 1'b0;
      req_reg       <= 1'b0;
    end else begin
      st_reg        <= st_next;
      temp_reg      <= temp_next;
      perm_reg      <= loaded_reg ? perm_next : nvm_perm;
      loaded_reg    <= 1'b1;
      nvm_wdata_reg <= nvm_wdata_next;
      nvm_wr_reg    <= nvm_wr_next;
      arb_reg       <= arb_next;
      err_reg       <= err_next;
      ext_reg       <= ext_next;
      req_reg       <= req_next;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg  <= 7'd0;
      sh_reg   <= 56'h0;
      txsh_reg <= 33'h0;
    end else if (crc_init) begin
      cnt_reg  <= 7'd0;
      txsh_reg <= {1'b0, cfg_word, handle};
    end else if ((st_reg == rfcc_pkg::T_RX && air.rx_valid) || in_tx) begin
      cnt_reg  <= cnt_reg + 7'd1;
      txsh_reg <= {txsh_reg[31:0], 1'b0};
      if (!in_tx && cnt_reg < `RFCC_CMD_BODY) begin
        sh_reg <= {sh_reg[54:0], air.rx_bit};
      end
    end
  end
endmodule

`default_nettype wire

/* hdl/rfcc_reader.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rfcc_defs.svh"

module rfcc_reader #(
  parameter int BIT_DIV     = 4,
  parameter int TIMEOUT_CYC = `RFCC_CW_MAX_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  rfcc_air_if.reader       air
);
  if (BIT_DIV < 1 || BIT_DIV > 65535) begin : g_bad_div
    $error("BIT_DIV out of range");
  end
  if (TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("TIMEOUT_CYC too small");
  end

  rfcc_pkg::rfcc_host_st_t st_reg;
  logic [15:0] mask_reg, hdl_reg, rn_reg, reply_reg;
  logic [4:0]  flag_reg, flag_set;
  logic [6:0]  cnt_reg;
  logic [15:0] div_reg;
  logic [31:0] tmr_reg;
  logic [55:0] csh_reg;
  logic [48:0] rsh_reg;
  logic [15:0] tcrc, rcrc;

  // --------------------------------------------------------------------------
  // apb decode, zero wait states
  // --------------------------------------------------------------------------
  wire acc    = psel && penable;
  wire wr     = acc && pwrite;
  wire a_ctrl = (paddr == `RFCC_A_CTRL);
  wire a_stat = (paddr == `RFCC_A_STAT);
  wire a_mask = (paddr == `RFCC_A_MASK);
  wire a_hdl  = (paddr == `RFCC_A_HANDLE);
  wire a_rn   = (paddr == `RFCC_A_RN16);
  wire a_rep  = (paddr == `RFCC_A_REPLY);
  wire mapped = a_ctrl | a_stat | a_mask | a_hdl | a_rn | a_rep;
  wire idle   = (st_reg == rfcc_pkg::H_IDLE);
  wire start  = wr && a_ctrl && pwdata[0] && idle;

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = a_stat ? {26'h0, flag_reg, !idle} :
                   a_mask ? {16'h0, mask_reg} :
                   a_hdl  ? {16'h0, hdl_reg} :
                   a_rn   ? {16'h0, rn_reg} :
                   a_rep  ? {16'h0, reply_reg} : 32'h0000_0000;

  // --------------------------------------------------------------------------
  // air side
  // --------------------------------------------------------------------------
  wire bit_en    = (st_reg == rfcc_pkg::H_SEND) && (div_reg == 16'(BIT_DIV - 1));
  wire body      = cnt_reg < `RFCC_CMD_BODY;
  wire in_wait   = (st_reg == rfcc_pkg::H_WAIT);
  wire timed_out = in_wait && (tmr_reg == 32'(TIMEOUT_CYC - 1));

  assign air.req_rn   = (st_reg == rfcc_pkg::H_REQ);
  assign air.fs       = (st_reg == rfcc_pkg::H_FS);
  assign air.rx_valid = bit_en;
  assign air.rx_bit   = body ? csh_reg[55] : ~tcrc[15];
  assign air.cw       = in_wait;

  rfcc_crc16 u_tcrc (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .init    (air.fs),
    .en      (bit_en && body),
    .din     (csh_reg[55]),
    .shift   (bit_en && !body),
    .crc     (tcrc)
  );

  rfcc_crc16 u_rcrc (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .init    (air.fs),
    .en      (in_wait && air.tx_valid),
    .din     (air.tx_bit),
    .shift   (1'b0),
    .crc     (rcrc)
  );

  // done, timeout, error, bad crc, extended preamble
  always_comb begin
    flag_set = 5'b00000;
    if (in_wait && air.tx_err) flag_set[`RFCC_S_ERROR - 1] = 1'b1;
    if (timed_out) flag_set[`RFCC_S_TIMEOUT - 1] = 1'b1;
    if (in_wait && air.tx_valid && air.tx_ext_pre) flag_set[`RFCC_S_EXTPRE - 1] = 1'b1;
    if (st_reg == rfcc_pkg::H_CHK) begin
      if (rcrc == `RFCC_CRC_RESIDUE && !rsh_reg[48]) flag_set[`RFCC_S_DONE - 1] = 1'b1;
      else flag_set[`RFCC_S_BADCRC - 1] = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // registers and sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= 16'h0000;
      hdl_reg  <= 16'h0000;
      rn_reg   <= 16'h0000;
      flag_reg <= 5'b00000;
    end else begin
      if (wr && a_mask) mask_reg <= pwdata[15:0];
      if (wr && a_hdl) hdl_reg <= pwdata[15:0];
      if (wr && a_rn) rn_reg <= pwdata[15:0];
      flag_reg <= (flag_reg & ~{5{start}}) | flag_set;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg    <= rfcc_pkg::H_IDLE;
      cnt_reg   <= 7'd0;
      div_reg   <= 16'h0000;
      tmr_reg   <= 32'h0000_0000;
      csh_reg   <= 56'h0;
      rsh_reg   <= 49'h0;
      reply_reg <= 16'h0000;
    end else begin
      unique case (st_reg)
        rfcc_pkg::H_IDLE: begin
          if (start) begin
            csh_reg <= {`RFCC_OPCODE, `RFCC_RFU_FIELD, mask_reg ^ rn_reg, hdl_reg};
            st_reg  <= rfcc_pkg::H_REQ;
          end
        end
        rfcc_pkg::H_REQ: st_reg <= rfcc_pkg::H_FS;
        rfcc_pkg::H_FS: begin
          cnt_reg <= 7'd0;
          div_reg <= 16'h0000;
          st_reg  <= rfcc_pkg::H_SEND;
        end
        rfcc_pkg::H_SEND: begin
          div_reg <= bit_en ? 16'h0000 : div_reg + 16'h0001;
          if (bit_en) begin
            cnt_reg <= cnt_reg + 7'd1;
            csh_reg <= {csh_reg[54:0], 1'b0};
            if (cnt_reg == `RFCC_CMD_BITS - 7'd1) begin
              tmr_reg <= 32'h0000_0000;
              st_reg  <= rfcc_pkg::H_WAIT;
            end
          end
        end
        rfcc_pkg::H_WAIT: begin
          tmr_reg <= tmr_reg + 32'h0000_0001;
          if (air.tx_valid) rsh_reg <= {rsh_reg[47:0], air.tx_bit};
          if (air.tx_valid && air.tx_last) st_reg <= rfcc_pkg::H_CHK;
          else if (air.tx_err || timed_out) st_reg <= rfcc_pkg::H_IDLE;
        end
        rfcc_pkg::H_CHK: begin
          if (rcrc == `RFCC_CRC_RESIDUE) reply_reg <= rsh_reg[47:32];
          st_reg <= rfcc_pkg::H_IDLE;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

/* tb/rfcc_air_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rfcc_air_asserts (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic req_rn,
  input wire logic fs,
  input wire logic rx_valid,
  input wire logic rx_bit,
  input wire logic cw,
  input wire logic tx_valid,
  input wire logic tx_bit,
  input wire logic tx_last,
  input wire logic tx_ext_pre,
  input wire logic tx_err
);
  // ---------------------------------
  // air link checks
  // ---------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_REQ_FS: assert property (req_rn |=> fs)
    else $error("frame sync missing after req");
  AST_FS_PULSE: assert property (fs |=> !fs && !req_rn)
    else $error("frame sync not a single pulse");
  AST_CW_QUIET: assert property (cw |-> !fs && !rx_valid)
    else $error("command bits during carrier wait");
  AST_REPLY_IN_CW: assert property ($rose(tx_valid) |-> cw)
    else $error("reply outside carrier wait");
  AST_CW_DROP: assert property (tx_last |-> ##2 !cw)
    else $error("carrier held after reply");
  AST_HEADER: assert property ($rose(tx_valid) |-> !tx_bit)
    else $error("reply header not zero");
  AST_REPLY_LEN: assert property ($rose(tx_valid) |-> ##48 tx_last)
    else $error("reply length wrong");
  AST_LAST_IN_TX: assert property (tx_last |-> tx_valid)
    else $error("last bit outside reply");
  AST_ERR_ALONE: assert property (tx_err |-> !tx_valid)
    else $error("error code during reply");
  AST_PRE_STABLE: assert property (tx_valid && $past(tx_valid) |-> $stable(tx_ext_pre))
    else $error("preamble flag changed in reply");
endmodule
`default_nettype wire

/* tb/rfcc_tag_feature_config_command_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", n, e, a); end end
module rfcc_tag_feature_config_command_tb_top;
  logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, apz = 0, nvm_done = 0, nvm_wr, ext_pad = 0;
  logic nvm_fail = 0, fail_mode = 0, epc_locked = 1, wr_req = 0, go_arb;
  logic [2:0] epc_blocks = 3'h0;
  logic [15:0] handle = 16'h5A3C, cfg_word, wr_data = 16'h0000;
  logic [8:0] nvm_perm = 9'h040, nvm_wdata;
  logic [9:0] epc_len, user_len;
  rfcc_pkg::rfcc_gen2_state_t gst = rfcc_pkg::G2_READY;
  int miscompares = 0, comparisons = 0, arb_cnt = 0;
  logic [43:0] rows [10] = '{{3'h5, 1'h0, 16'h0002, 16'h8042, 8'h22},
    {3'h5, 1'h0, 16'h0002, 16'h8040, 8'h22}, {3'h5, 1'h0, 16'h0011, 16'h8051, 8'h22},
    {3'h4, 1'h0, 16'h0011, 16'h8051, 8'h02}, {3'h5, 1'h1, 16'h0011, 16'h8051, 8'h02},
    {3'h5, 1'h0, 16'h3000, 16'h8051, 8'h04}, {3'h0, 1'h0, 16'h0011, 16'h8051, 8'h04},
    {3'h1, 1'h0, 16'h0011, 16'h8051, 8'h04}, {3'h6, 1'h0, 16'h0011, 16'h8051, 8'h04},
    {3'h5, 1'h0, 16'h8800, 16'h8851, 8'h22}};
  rfcc_air_if air ();
  rfcc_reader #(.BIT_DIV(1), .TIMEOUT_CYC(2000)) rfcc_reader_inst (.ref_clk(ref_clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .air(air));
  rfcc_tag rfcc_tag_inst (.ref_clk(ref_clk), .nrst(nrst), .air(air), .gen2_state(gst),
    .handle(handle), .rn16(16'h1234), .access_pw_zero(apz), .epc_locked(epc_locked),
    .tamper_pad(1'b1), .ext_supply_pad(ext_pad), .nvm_perm(nvm_perm),
    .nvm_done(nvm_done), .nvm_fail(nvm_fail), .wr_req(wr_req), .wr_data(wr_data),
    .epc_extra_blocks(epc_blocks), .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata),
    .cfg_word(cfg_word), .go_arbitrate(go_arb), .epc_len_bits(epc_len),
    .user_len_bits(user_len));
  rfcc_air_asserts rfcc_air_asserts_inst (.ref_clk(ref_clk), .nrst(nrst),
    .req_rn(air.req_rn), .fs(air.fs), .rx_valid(air.rx_valid), .rx_bit(air.rx_bit),
    .cw(air.cw), .tx_valid(air.tx_valid), .tx_bit(air.tx_bit), .tx_last(air.tx_last),
    .tx_ext_pre(air.tx_ext_pre), .tx_err(air.tx_err));
  // ---------------------------------
  // clock, memory answer, tasks
  // ---------------------------------
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    nvm_done <= nvm_wr && !fail_mode;
    nvm_fail <= nvm_wr && fail_mode;
    if (nvm_wr && !fail_mode) nvm_perm <= nvm_wdata;
    if (go_arb === 1'b1) arb_cnt <= arb_cnt + 1;
  end
  task automatic finish_test();
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic run(input logic [43:0] r);
    gst <= rfcc_pkg::rfcc_gen2_state_t'(r[43:41]);
    apz <= r[40];
    apb(1, 8'h08, {16'h0000, r[39:24]});
    apb(1, 8'h00, 32'h0000_0001);
    do apb(0, 8'h04, 32'h0000_0000); while (rd[0] !== 1'b0);
    `CHK("stat", {24'h00_0000, r[7:0]}, rd)
    apb(0, 8'h14, 32'h0000_0000);
    `CHK("reply", {16'h0000, r[23:8]}, rd)
  endtask
  task automatic std_wr(input logic lock, input logic [15:0] exp);
    epc_locked <= lock;
    wr_data <= 16'h3E3F;
    wr_req <= 1;
    @(posedge ref_clk);
    wr_req <= 0;
    repeat (2) @(posedge ref_clk);
    `CHK("std write", exp, cfg_word)
  endtask
  // ---------------------------------
  // tests
  // ---------------------------------
  initial begin
    #(20 * 60000);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1;
    apb(1, 8'h0C, 32'h0000_5A3C);
    apb(1, 8'h10, 32'h0000_1234);
    for (int i = 0; i < 10; i++) run(rows[i]);
    `CHK("arbitrate", 1, arb_cnt)
    fail_mode <= 1;
    run({3'h5, 1'h0, 16'h0002, 16'h8851, 8'h08});
    fail_mode <= 0;
    handle <= 16'hFFFF;
    run({3'h5, 1'h0, 16'h0002, 16'h8851, 8'h04});
    apb(0, 8'h3C, 32'h0000_0000);
    `CHK("unmapped", 1'b1, er)
    std_wr(1, 16'h8851);
    std_wr(0, 16'h8E3F);
    ext_pad <= 1;
    nrst <= 0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1;
    repeat (10) @(posedge ref_clk);
    `CHK("word after reset", 16'hC03F, cfg_word)
    `CHK("epc bits", 10'd128, epc_len)
    `CHK("user bits", 10'd640, user_len)
    epc_blocks <= 3'h7;
    @(posedge ref_clk);
    `CHK("epc bits max", 10'd448, epc_len)
    `CHK("user bits min", 10'd320, user_len)
    finish_test();
  end
endmodule
`default_nettype wire
